// File: core/afct_defines.svh
// Constants of the automatic flow control trigger
`ifndef AFCT_DEFINES_SVH
`define AFCT_DEFINES_SVH

// Register byte offsets
`define AFCT_CFG_OFF        8'hac
`define AFCT_STAT_OFF       8'hc0

// Configuration fields
`define AFCT_HI_MSB         23
`define AFCT_HI_LSB         16
`define AFCT_LO_MSB         15
`define AFCT_LO_LSB         8
`define AFCT_DUR_MSB        7
`define AFCT_DUR_LSB        4
`define AFCT_MULT_BIT       3
`define AFCT_BRD_BIT        2
`define AFCT_ADD_BIT        1
`define AFCT_ANY_BIT        0
`define AFCT_CFG_RST        32'h0000_0000
`define AFCT_CFG_MASK       32'h00ff_ffff

// Status fields
`define AFCT_ST_ABOVE_BIT   0
`define AFCT_ST_BP_BIT      1
`define AFCT_ST_PAUSED_BIT  2
`define AFCT_ST_PREQ_BIT    3
`define AFCT_ST_CNT_LSB     16

// Fill level unit is 64 bytes
`define AFCT_FILL_SHIFT     6
`define AFCT_FILL_W         14

// AXI4-Lite responses
`define AFCT_RESP_OKAY      2'b00
`define AFCT_RESP_SLVERR    2'b10

// Timing
`define AFCT_CLK_NS         40
`define AFCT_BP_T0_NS       5000
`define AFCT_BP_T1_NS       10000
`define AFCT_BP_T2_NS       15000
`define AFCT_BP_T3_NS       25000
`define AFCT_BP_STEP_NS     50000
`define AFCT_BP_10M_NS      2200
`define AFCT_NS2CYC(t)      ((t) / `AFCT_CLK_NS)

`endif

// File: core/afct_pkg.sv
// Types of the automatic flow control trigger
package afct_pkg;
  typedef enum logic [1:0] {
    AFCT_IDLE,
    AFCT_REQ_PAUSE,
    AFCT_PAUSED,
    AFCT_REQ_ZERO
  } afct_fc_state_t;

  typedef logic [15:0] afct_cyc_t;
endpackage : afct_pkg

// File: core/afct_dur_rom.sv
// Back-pressure duration lookup, registered
`timescale 1ns/100ps
`default_nettype none
`include "afct_defines.svh"
module afct_dur_rom #(
  parameter int unsigned P_STEP_CYC = `AFCT_NS2CYC(`AFCT_BP_STEP_NS)
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // Lookup
  input  wire logic [3:0]        i_code,
  input  wire logic              i_speed_100,
  output var  afct_pkg::afct_cyc_t o_cyc_q
);
  localparam afct_pkg::afct_cyc_t EXTRA_CYC = 16'(`AFCT_NS2CYC(`AFCT_BP_10M_NS));
  localparam afct_pkg::afct_cyc_t SMALL_CYC [4] = '{
    16'(`AFCT_NS2CYC(`AFCT_BP_T0_NS)),
    16'(`AFCT_NS2CYC(`AFCT_BP_T1_NS)),
    16'(`AFCT_NS2CYC(`AFCT_BP_T2_NS)),
    16'(`AFCT_NS2CYC(`AFCT_BP_T3_NS))
  };

  afct_pkg::afct_cyc_t tbl [16];
  afct_pkg::afct_cyc_t sel;

  // Table entries
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_tbl
      if (gi < 4) begin : g_small
        assign tbl[gi] = SMALL_CYC[gi];
      end else begin : g_step
        assign tbl[gi] = 16'(P_STEP_CYC * (gi - 3));
      end
    end
  endgenerate

  assign sel = i_speed_100 ? tbl[i_code] : 16'(tbl[i_code] + EXTRA_CYC);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cyc_q <= 16'h0000;
    end else begin
      o_cyc_q <= sel;
    end
  end
endmodule : afct_dur_rom
`default_nettype wire

// File: core/afct_top.sv
// Automatic flow control trigger with AXI4-Lite registers
//
// Overview of operation
// - The high threshold counts receive FIFO fill in 64-byte units and reaching it arms back pressure or pause.
// - After a pause frame sent at the high level, a zero-time pause is sent once fill drops below the low level.
// - In half duplex above the high threshold, each incoming frame matching the trigger selection is jammed for the set duration.
// - Automatic back pressure is held for the time chosen by the 4-bit duration code.
// - In full duplex the duration code is ignored and no back pressure is applied.
// - The multicast trigger jams multicast frames in half duplex above threshold, and does nothing in full duplex.
// - The broadcast trigger jams broadcast frames in half duplex above threshold, and does nothing in full duplex.
// - The own-address trigger jams frames to this station in half duplex above threshold, not in full duplex.
// - The any-frame trigger acts on every frame above threshold and is the full-duplex flow control enable.
// - In half duplex with any-frame set, jamming starts on a valid preamble without address decoding.
// - In full duplex with any-frame set, a pause request goes to the MAC as soon as the threshold is reached.
// - With any-frame set, the multicast, broadcast and own-address triggers are ignored.
// - Durations are 5, 10, 15, 25 us then 50 us steps to 600 us at 100 Mb/s, each 2.2 us longer at 10 Mb/s.
`timescale 1ns/100ps
`default_nettype none
`include "afct_defines.svh"
module afct_top #(
  parameter int unsigned P_BP_STEP_CYC = `AFCT_NS2CYC(`AFCT_BP_STEP_NS)
) (
  // Clock and reset
  input  wire logic                     I_CLK,
  input  wire logic                     I_RST_N,
  // AXI4-Lite write address
  input  wire logic                     I_AWVALID,
  output var  logic                     O_AWREADY,
  input  wire logic [7:0]               I_AWADDR,
  // AXI4-Lite write data
  input  wire logic                     I_WVALID,
  output var  logic                     O_WREADY,
  input  wire logic [31:0]              I_WDATA,
  input  wire logic [3:0]               I_WSTRB,
  // AXI4-Lite write response
  output var  logic                     O_BVALID,
  input  wire logic                     I_BREADY,
  output var  logic [1:0]               O_BRESP,
  // AXI4-Lite read address
  input  wire logic                     I_ARVALID,
  output var  logic                     O_ARREADY,
  input  wire logic [7:0]               I_ARADDR,
  // AXI4-Lite read data
  output var  logic                     O_RVALID,
  input  wire logic                     I_RREADY,
  output var  logic [31:0]              O_RDATA,
  output var  logic [1:0]               O_RRESP,
  // MAC link state
  input  wire logic                     I_FULL_DUPLEX,
  input  wire logic                     I_SPEED_100,
  // Receive FIFO fill in bytes
  input  wire logic [`AFCT_FILL_W-1:0]  I_RX_FIFO_BYTES,
  // Receive frame events
  input  wire logic                     I_RX_PREAMBLE,
  input  wire logic                     I_RX_ADDR_VALID,
  input  wire logic                     I_RX_IS_MCAST,
  input  wire logic                     I_RX_IS_BCAST,
  input  wire logic                     I_RX_IS_OWN,
  // Pause request to MAC
  output var  logic                     O_PAUSE_REQ,
  output var  logic                     O_PAUSE_ZERO,
  input  wire logic                     I_PAUSE_ACK,
  // Back pressure to MAC
  output var  logic                     O_BACKPRESSURE
);

  // Register state
  logic [31:0]               cfg_q;
  logic [31:0]               cfg_d;
  logic                      awready_q;
  logic                      wready_q;
  logic                      bvalid_q;
  logic [1:0]                bresp_q;
  logic [7:0]                awaddr_q;
  logic [31:0]               wdata_q;
  logic [3:0]                wstrb_q;
  logic                      arready_q;
  logic                      rvalid_q;
  logic [31:0]               rdata_q;
  logic [1:0]                rresp_q;

  // Flow control state
  afct_pkg::afct_fc_state_t  fc_q;
  afct_pkg::afct_fc_state_t  fc_d;
  afct_pkg::afct_cyc_t       cnt_q;
  afct_pkg::afct_cyc_t       dur_cyc;
  logic                      bp_q;
  logic                      preq_q;
  logic                      pzero_q;

  // Configuration fields
  wire logic [7:0]           hi_thr   = cfg_q[`AFCT_HI_MSB:`AFCT_HI_LSB];
  wire logic [7:0]           lo_thr   = cfg_q[`AFCT_LO_MSB:`AFCT_LO_LSB];
  wire logic [3:0]           dur_code = cfg_q[`AFCT_DUR_MSB:`AFCT_DUR_LSB];
  wire logic                 trg_mult = cfg_q[`AFCT_MULT_BIT];
  wire logic                 trg_brd  = cfg_q[`AFCT_BRD_BIT];
  wire logic                 trg_add  = cfg_q[`AFCT_ADD_BIT];
  wire logic                 trg_any  = cfg_q[`AFCT_ANY_BIT];

  // Fill level in 64-byte units
  wire logic [7:0]           fill_units;
  wire logic                 above_hi;
  wire logic                 below_lo;
  assign fill_units = I_RX_FIFO_BYTES[`AFCT_FILL_W-1:`AFCT_FILL_SHIFT];
  assign above_hi   = fill_units >= hi_thr;
  assign below_lo   = fill_units < lo_thr;

  // Write channel decode
  wire logic                 aw_hs;
  wire logic                 w_hs;
  wire logic                 b_hs;
  wire logic                 wr_go;
  wire logic                 wr_cfg;
  wire logic                 wr_stat;
  wire logic [31:0]          wr_mask;
  assign aw_hs   = I_AWVALID & awready_q;
  assign w_hs    = I_WVALID & wready_q;
  assign b_hs    = bvalid_q & I_BREADY;
  assign wr_go   = ~awready_q & ~wready_q & ~bvalid_q;
  assign wr_cfg  = wr_go & (awaddr_q == `AFCT_CFG_OFF);
  assign wr_stat = wr_go & (awaddr_q == `AFCT_STAT_OFF);
  assign wr_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign cfg_d   = ((cfg_q & ~wr_mask) | (wdata_q & wr_mask)) & `AFCT_CFG_MASK;

  // Read channel decode
  wire logic                 ar_hs;
  wire logic                 r_hs;
  wire logic                 rd_cfg;
  wire logic                 rd_stat;
  wire logic [31:0]          stat_word;
  wire logic [31:0]          rd_word;
  assign ar_hs   = I_ARVALID & arready_q;
  assign r_hs    = rvalid_q & I_RREADY;
  assign rd_cfg  = I_ARADDR == `AFCT_CFG_OFF;
  assign rd_stat = I_ARADDR == `AFCT_STAT_OFF;
  assign stat_word = {cnt_q, 12'h000, preq_q, (fc_q == afct_pkg::AFCT_PAUSED), bp_q, above_hi};
  assign rd_word = rd_cfg ? (cfg_q & `AFCT_CFG_MASK) : (rd_stat ? stat_word : 32'h0000_0000);

  // Write address and data capture
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (aw_hs) begin
        awready_q <= 1'b0;
        awaddr_q  <= I_AWADDR;
      end else if (b_hs) begin
        awready_q <= 1'b1;
      end
      if (w_hs) begin
        wready_q <= 1'b0;
        wdata_q  <= I_WDATA;
        wstrb_q  <= I_WSTRB;
      end else if (b_hs) begin
        wready_q <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `AFCT_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_cfg | wr_stat) ? `AFCT_RESP_OKAY : `AFCT_RESP_SLVERR;
    end else if (b_hs) begin
      bvalid_q <= 1'b0;
    end
  end

  // Configuration register
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cfg_q <= `AFCT_CFG_RST;
    end else if (wr_cfg) begin
      cfg_q <= cfg_d;
    end
  end

  // Read channel
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `AFCT_RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= (rd_cfg | rd_stat) ? `AFCT_RESP_OKAY : `AFCT_RESP_SLVERR;
    end else if (r_hs) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // Duration lookup
  afct_dur_rom #(
    .P_STEP_CYC (P_BP_STEP_CYC)
  ) u_dur_rom (
    .i_clk       (I_CLK),
    .i_rst_n     (I_RST_N),
    .i_code      (dur_code),
    .i_speed_100 (I_SPEED_100),
    .o_cyc_q     (dur_cyc)
  );

  // Half-duplex frame match
  wire logic                 hd_active;
  wire logic                 sel_match;
  wire logic                 any_start;
  wire logic                 sel_start;
  wire logic                 jam_start;
  assign hd_active = ~I_FULL_DUPLEX & above_hi;
  assign sel_match = (trg_mult & I_RX_IS_MCAST)
                   | (trg_brd & I_RX_IS_BCAST)
                   | (trg_add & I_RX_IS_OWN);
  assign any_start = hd_active & trg_any & I_RX_PREAMBLE;
  assign sel_start = hd_active & ~trg_any & I_RX_ADDR_VALID & sel_match;
  assign jam_start = any_start | sel_start;

  // Back-pressure down-counter
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cnt_q <= 16'h0000;
      bp_q  <= 1'b0;
    end else if (I_FULL_DUPLEX) begin
      cnt_q <= 16'h0000;
      bp_q  <= 1'b0;
    end else if (jam_start) begin
      cnt_q <= dur_cyc;
      bp_q  <= 1'b1;
    end else if (cnt_q > 16'h0001) begin
      cnt_q <= 16'(cnt_q - 16'h0001);
    end else begin
      cnt_q <= 16'h0000;
      bp_q  <= 1'b0;
    end
  end

  // Full-duplex pause sequencing
  wire logic                 fd_trig;
  assign fd_trig = I_FULL_DUPLEX & trg_any & above_hi;

  always_comb begin
    fc_d = fc_q;
    case (fc_q)
      afct_pkg::AFCT_IDLE: begin
        if (fd_trig) begin
          fc_d = afct_pkg::AFCT_REQ_PAUSE;
        end
      end
      afct_pkg::AFCT_REQ_PAUSE: begin
        if (I_PAUSE_ACK) begin
          fc_d = afct_pkg::AFCT_PAUSED;
        end
      end
      afct_pkg::AFCT_PAUSED: begin
        if (below_lo) begin
          fc_d = afct_pkg::AFCT_REQ_ZERO;
        end
      end
      afct_pkg::AFCT_REQ_ZERO: begin
        if (I_PAUSE_ACK) begin
          fc_d = afct_pkg::AFCT_IDLE;
        end
      end
      default: begin
        fc_d = afct_pkg::AFCT_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fc_q    <= afct_pkg::AFCT_IDLE;
      preq_q  <= 1'b0;
      pzero_q <= 1'b0;
    end else begin
      fc_q    <= fc_d;
      preq_q  <= (fc_d == afct_pkg::AFCT_REQ_PAUSE) | (fc_d == afct_pkg::AFCT_REQ_ZERO);
      pzero_q <= fc_d == afct_pkg::AFCT_REQ_ZERO;
    end
  end

  // Outputs
  assign O_AWREADY      = awready_q;
  assign O_WREADY       = wready_q;
  assign O_BVALID       = bvalid_q;
  assign O_BRESP        = bresp_q;
  assign O_ARREADY      = arready_q;
  assign O_RVALID       = rvalid_q;
  assign O_RDATA        = rdata_q;
  assign O_RRESP        = rresp_q;
  assign O_PAUSE_REQ    = preq_q;
  assign O_PAUSE_ZERO   = pzero_q;
  assign O_BACKPRESSURE = bp_q;

endmodule : afct_top
`default_nettype wire

// File: testbench/afct_properties.sv
// Port checker of the flow control trigger
`timescale 1ns/100ps
`default_nettype none
module afct_checker #(
  parameter int unsigned P_BP_STEP_CYC = 4
) (
  // Clock and reset
  input wire logic       I_CLK,
  input wire logic       I_RST_N,
  // Register bus
  input wire logic       O_BVALID,
  input wire logic       I_BREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic       I_ARVALID,
  input wire logic       O_ARREADY,
  input wire logic       O_RVALID,
  // Flow control
  input wire logic       I_FULL_DUPLEX,
  input wire logic       I_RX_PREAMBLE,
  input wire logic       I_RX_ADDR_VALID,
  input wire logic       O_PAUSE_REQ,
  input wire logic       O_PAUSE_ZERO,
  input wire logic       I_PAUSE_ACK,
  input wire logic       O_BACKPRESSURE
);
  localparam int LIM = ((12 * P_BP_STEP_CYC > 625) ? 12 * P_BP_STEP_CYC : 625) + 56;
  logic [15:0] run_q;
  logic [15:0] run_d;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  // Length of one jam run
  assign run_d = (O_BACKPRESSURE && !I_RX_PREAMBLE && !I_RX_ADDR_VALID) ? run_q + 16'h1 : 16'h0;
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      run_q <= 16'h0;
    end else begin
      run_q <= run_d;
    end
  end
  a_fd_no_bp: assert property (
    I_FULL_DUPLEX |=> !O_BACKPRESSURE) else $error("jam in full duplex");
  a_bp_on_frame: assert property (
    $rose(O_BACKPRESSURE) |-> ($past(I_RX_PREAMBLE) || $past(I_RX_ADDR_VALID)) && !$past(I_FULL_DUPLEX))
    else $error("jam without frame");
  a_bp_min_hold: assert property (
    $rose(O_BACKPRESSURE) |-> O_BACKPRESSURE[*4]) else $error("jam too short");
  a_bp_max_len: assert property (
    run_q <= LIM) else $error("jam too long");
  a_pause_fd: assert property (
    $rose(O_PAUSE_REQ) |-> $past(I_FULL_DUPLEX)) else $error("pause in half duplex");
  a_pause_hold: assert property (
    O_PAUSE_REQ && !I_PAUSE_ACK |=> O_PAUSE_REQ && $stable(O_PAUSE_ZERO)) else $error("pause dropped");
  a_bresp_hold: assert property (
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP)) else $error("write response dropped");
  a_read_answer: assert property (
    I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY) else $error("read not answered");
endmodule : afct_checker

bind afct_top afct_checker #(.P_BP_STEP_CYC(P_BP_STEP_CYC)) u_chk (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_BRESP(O_BRESP),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .I_FULL_DUPLEX(I_FULL_DUPLEX),
  .I_RX_PREAMBLE(I_RX_PREAMBLE), .I_RX_ADDR_VALID(I_RX_ADDR_VALID), .O_PAUSE_REQ(O_PAUSE_REQ),
  .O_PAUSE_ZERO(O_PAUSE_ZERO), .I_PAUSE_ACK(I_PAUSE_ACK), .O_BACKPRESSURE(O_BACKPRESSURE)
);
`default_nettype wire

// File: testbench/afct_link_partner.sv
// Remote link partner sending frame events
`timescale 1ns/100ps
`default_nettype none
module afct_link_partner (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Frame launch
  input  wire logic       i_send,
  input  wire logic [1:0] i_kind,
  // Frame events
  output var  logic       o_preamble,
  output var  logic       o_addr_valid,
  output var  logic       o_own,
  output var  logic       o_bcast,
  output var  logic       o_mcast
);
  logic [2:0] stage_q;
  logic [1:0] kind_q;
  logic [1:0] idle_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage_q <= 3'h0;
      kind_q  <= 2'h0;
      idle_q  <= 2'h0;
    end else begin
      stage_q <= {stage_q[1:0], i_send};
      idle_q  <= idle_q + 2'h1;
      if (i_send) kind_q <= i_kind;
    end
  end
  // Flags toggle outside the address slot
  assign o_preamble   = stage_q[0];
  assign o_addr_valid = stage_q[2];
  assign o_own        = o_addr_valid ? kind_q == 2'h1 : idle_q[0];
  assign o_bcast      = o_addr_valid ? kind_q == 2'h2 : idle_q[1];
  assign o_mcast      = o_addr_valid ? kind_q == 2'h3 : ~idle_q[0];
endmodule : afct_link_partner
`default_nettype wire

// File: testbench/auto_flow_control_trigger_bench.sv
// Self-checking bench of the flow control trigger
`timescale 1ns/100ps
`default_nettype none
`include "afct_defines.svh"
module auto_flow_control_trigger_bench;
  localparam int unsigned STEP = 4;
  int codes[4] = '{0, 4, 15, 4};
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic fd = 1'b0, s100 = 1'b1, send = 1'b0, ack = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'h0;
  logic [13:0] fill = 14'h0;
  logic [1:0] kind = 2'h0;
  logic awr, wr, bv, arr, rv, pre, adv, mc, bc, own, preq, pz, bp;
  logic [1:0] br, rr;
  logic [31:0] rd;
  initial begin
    forever #20 clk = ~clk;
  end
  afct_top #(.P_BP_STEP_CYC(STEP)) u_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa),
    .I_WVALID(wv), .O_WREADY(wr), .I_WDATA(wd), .I_WSTRB(ws), .O_BVALID(bv), .I_BREADY(bry),
    .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv),
    .I_RREADY(rry), .O_RDATA(rd), .O_RRESP(rr), .I_FULL_DUPLEX(fd), .I_SPEED_100(s100),
    .I_RX_FIFO_BYTES(fill), .I_RX_PREAMBLE(pre), .I_RX_ADDR_VALID(adv), .I_RX_IS_MCAST(mc),
    .I_RX_IS_BCAST(bc), .I_RX_IS_OWN(own), .O_PAUSE_REQ(preq), .O_PAUSE_ZERO(pz),
    .I_PAUSE_ACK(ack), .O_BACKPRESSURE(bp)
  );
  afct_link_partner u_link (
    .i_clk(clk), .i_rst_n(rst_n), .i_send(send), .i_kind(kind), .o_preamble(pre),
    .o_addr_valid(adv), .o_own(own), .o_bcast(bc), .o_mcast(mc)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (n == 2) bry <= 1'b1;
    end while (!(bv && bry) && n < 40);
    check({31'h0, bv}, 32'h1, "write answered");
    bry <= 1'b0;
    check({30'h0, br}, {30'h0, er}, "write response");
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'b0;
      if (n == 2) rry <= 1'b1;
    end while (!(rv && rry) && n < 40);
    check({31'h0, rv}, 32'h1, "read answered");
    rry <= 1'b0;
    check(rd, ed, "read data");
    check({30'h0, rr}, {30'h0, er}, "read response");
  endtask : axi_read
  task automatic setcfg(input logic [3:0] code, input logic [3:0] trig);
    axi_write(`AFCT_CFG_OFF, {16'h0002, 8'h01, code, trig}, 4'hf, 2'b00);
  endtask : setcfg
  function automatic int dur(input int c, input logic fast);
    int t[4] = '{125, 250, 375, 625};
    dur = (c < 4 ? t[c] : STEP * (c - 3)) + (fast ? 0 : 55);
  endfunction : dur
  // Sends one frame, measures delay to jam and jam length
  task automatic frame(input logic [1:0] k, input int dly, input int len);
    int n, m;
    m = 0;
    @(posedge clk);
    kind <= k;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    n = 1;
    while (!bp && n < 12) begin
      @(posedge clk);
      n++;
    end
    while (bp && m < 2000) begin
      @(posedge clk);
      m++;
    end
    check(n, dly, "jam delay");
    check(m, len, "jam length");
  endtask : frame
  task automatic pause(input logic z);
    int n;
    n = 0;
    while (!preq && n < 20) begin
      @(posedge clk);
      n++;
    end
    check(n, 2, "pause delay");
    check({31'h0, pz}, {31'h0, z}, "pause zero");
    repeat (3) @(posedge clk);
    check({31'h0, preq}, 32'h1, "pause held");
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    @(posedge clk);
    check({31'h0, preq}, 32'h0, "pause done");
  endtask : pause
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    axi_read(`AFCT_CFG_OFF, 32'h0, 2'b00);
    axi_read(8'hf0, 32'h0, 2'b10);
    axi_write(8'hf0, 32'hffff_ffff, 4'hf, 2'b10);
    axi_write(`AFCT_STAT_OFF, 32'h0, 4'hf, 2'b00);
    axi_write(`AFCT_CFG_OFF, 32'hff02_0141, 4'hf, 2'b00);
    axi_read(`AFCT_CFG_OFF, 32'h0002_0141, 2'b00);
    axi_write(`AFCT_CFG_OFF, 32'hffff_ff0f, 4'h1, 2'b00);
    axi_read(`AFCT_CFG_OFF, 32'h0002_010f, 2'b00);
    fill <= 14'd127;
    frame(2'd0, 12, 0);
    fill <= 14'd128;
    frame(2'd3, 3, dur(0, 1'b1));
    for (int i = 0; i < 4; i++) begin
      s100 <= (i != 3);
      setcfg(codes[i][3:0], 4'h1);
      frame(2'd0, 3, dur(codes[i], i != 3));
    end
    s100 <= 1'b1;
    for (int b = 1; b < 4; b++) begin
      setcfg(4'h4, 4'(1 << b));
      frame(2'(b), 5, STEP);
      frame(2'(b % 3 + 1), 12, 0);
    end
    fd <= 1'b1;
    setcfg(4'h0, 4'h8);
    frame(2'd3, 12, 0);
    check({31'h0, preq}, 32'h0, "pause on multicast");
    fill <= 14'd0;
    setcfg(4'h0, 4'h1);
    fill <= 14'd128;
    pause(1'b0);
    axi_read(`AFCT_STAT_OFF, 32'h0000_0005, 2'b00);
    frame(2'd0, 12, 0);
    fill <= 14'd63;
    pause(1'b1);
    finish_test();
  end
endmodule : auto_flow_control_trigger_bench
`default_nettype wire
